/* dolc_regs.vh */
`ifndef DOLC_REGS_VH
`define DOLC_REGS_VH
`define DOLC_ADDR_CTRL      4'h0
`define DOLC_ADDR_CFG       4'h4
`define DOLC_ADDR_STATUS    4'h8
`define DOLC_ADDR_OSCDIV    4'hc
`define DOLC_CTRL_OVERRIDE  8'h01
`define DOLC_CFG_IDLE_BIT   0
`define DOLC_CFG_OSCEN_BIT  1
`define DOLC_CFG_EQ_BIT     2
`define DOLC_CFG_LFR_BIT    3
`define DOLC_CFG_SSC_LSB    4
`define DOLC_CFG_OSCCK_BIT  7
`define DOLC_CFG_RESET      8'h00
`define DOLC_OSCDIV_RESET   8'h04
`define DOLC_LOCK_EDGES     8'h10
`define DOLC_LOSS_CYCLES    8'h40
`define DOLC_SSC_DIV_HI_A   12'd2168
`define DOLC_SSC_DIV_HI_B   12'd1300
`define DOLC_SSC_DIV_LO_A   12'd625
`define DOLC_SSC_DIV_LO_B   12'd385
`endif

/* dolc_sync.v */
`timescale 1ns/100ps
`default_nettype none
module dolc_sync (
  input  wire       core_clk,
  input  wire       rst,
  input  wire [7:0] asyncIn,
  output reg  [7:0] syncOut
);
  reg [7:0] stage1Reg;
  reg [7:0] stage2Reg;
  reg [7:0] stage3Reg;

  // Value accepted only once the second and third stages agree
  always @(posedge core_clk) begin
    if (rst) begin
      stage1Reg <= 8'h00;
      stage2Reg <= 8'h00;
      stage3Reg <= 8'h00;
      syncOut   <= 8'h00;
    end else begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
      stage3Reg <= stage2Reg;
      syncOut   <= (stage2Reg & stage3Reg) | (syncOut & (stage2Reg | stage3Reg));
    end
  end
endmodule
`default_nettype wire

/* dolc_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "dolc_regs.vh"
module dolc_top (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        powerDownN,
  input  wire        outDriveEnable,
  input  wire        idleOutputSelectStrap,
  input  wire        fallbackOscSelectStrap,
  input  wire        rxEqualizerBoostStrap,
  input  wire        lowFreqRangeSelStrap,
  input  wire [2:0]  spreadCodeStrap,
  input  wire        autoDetectMode,
  input  wire        recoveredClk,
  input  wire        embeddedClkPresent,
  input  wire [3:0]  recoveredData,
  input  wire        selfTestResult,
  output reg         lockOut,
  output reg         parallelClockOut,
  output reg         parallelClockOutEn,
  output reg  [3:0]  parallelDataLanes,
  output reg  [3:0]  parallelDataLanesEn,
  output reg         passOut,
  output reg         passOutEn,
  output reg         rxEqualizerBoost,
  output reg         sleepState,
  output reg         sscActive,
  output reg  [11:0] sscDivider,
  output reg  [2:0]  sscDeviationCode,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  localparam [3:0] ST_DOWN = 4'b0001;
  localparam [3:0] ST_SEEK = 4'b0010;
  localparam [3:0] ST_LOCK = 4'b0100;
  localparam [3:0] ST_SLEEP = 4'b1000;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [7:0] syncPins;
  dolc_sync pinSync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  ({2'b00, powerDownN, outDriveEnable, recoveredClk, embeddedClkPresent, idleOutputSelectStrap,
                fallbackOscSelectStrap}),
    .syncOut  (syncPins)
  );
  wire pdnS    = syncPins[5];
  wire oenS    = syncPins[4];
  wire rclkS   = syncPins[3];
  wire embS    = syncPins[2];
  wire idleStr = syncPins[1];
  wire oscStr  = syncPins[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] ctrl_reg;
  reg [7:0] cfg_reg;
  reg [7:0] oscDiv_reg;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [7:0] edgeCnt_reg;
  reg [7:0] lossCnt_reg;
  reg       rclkPrev_reg;
  reg [7:0] oscCnt_reg;
  reg       oscClk_reg;
  reg       useOsc_reg;
  reg [3:0] awAddr_reg;
  reg       awHave_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;
  reg       wHave_reg;

  wire regMode  = (ctrl_reg == `DOLC_CTRL_OVERRIDE);
  wire idleSel  = regMode ? cfg_reg[`DOLC_CFG_IDLE_BIT] : idleStr;
  wire oscSel   = regMode ? cfg_reg[`DOLC_CFG_OSCEN_BIT] : oscStr;
  wire lfrSel   = regMode ? cfg_reg[`DOLC_CFG_LFR_BIT] : lowFreqRangeSelStrap;
  wire [2:0] sscSel = regMode ? cfg_reg[`DOLC_CFG_SSC_LSB+2:`DOLC_CFG_SSC_LSB] : spreadCodeStrap;
  wire rclkRise = rclkS & ~rclkPrev_reg;
  wire rclkEdge = rclkS ^ rclkPrev_reg;
  wire locked   = (state_reg == ST_LOCK);
  wire enterDown = (state_reg != ST_DOWN) && (state_next == ST_DOWN);

  // Spread divider select: lower band when range select is high
  function [11:0] sscDivFor;
    input       lfr;
    input [2:0] code;
    begin
      if (code == 3'b000)
        sscDivFor = 12'd0;
      else if (lfr)
        sscDivFor = code[2] && (code[1:0] != 2'b00) ? `DOLC_SSC_DIV_LO_B : `DOLC_SSC_DIV_LO_A;
      else
        sscDivFor = code[2] && (code[1:0] != 2'b00) ? `DOLC_SSC_DIV_HI_B : `DOLC_SSC_DIV_HI_A;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Lock state machine
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_DOWN: begin
        if (pdnS && (!autoDetectMode || embS))
          state_next = ST_SEEK;
      end
      ST_SEEK: begin
        if (!pdnS)
          state_next = ST_DOWN;
        else if (edgeCnt_reg >= `DOLC_LOCK_EDGES)
          state_next = ST_LOCK;
      end
      ST_LOCK: begin
        if (!pdnS)
          state_next = ST_DOWN;
        else if (!embS || lossCnt_reg >= `DOLC_LOSS_CYCLES)
          state_next = autoDetectMode ? ST_DOWN : ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!pdnS)
          state_next = ST_DOWN;
        else if (embS)
          state_next = ST_SEEK;
      end
      default: state_next = ST_DOWN;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      state_reg    <= ST_DOWN;
      edgeCnt_reg  <= 8'h00;
      lossCnt_reg  <= 8'h00;
      rclkPrev_reg <= 1'b0;
      lockOut      <= 1'b0;
      sleepState   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      rclkPrev_reg <= rclkS;
      lockOut      <= (state_next == ST_LOCK);
      sleepState   <= (state_next == ST_SLEEP) || (state_next == ST_DOWN);
      if (state_reg != ST_SEEK || !embS)
        edgeCnt_reg <= 8'h00;
      else if (rclkRise && edgeCnt_reg != 8'hff)
        edgeCnt_reg <= edgeCnt_reg + 8'h01;
      if (rclkEdge || !locked)
        lossCnt_reg <= 8'h00;
      else if (lossCnt_reg != 8'hff)
        lossCnt_reg <= lossCnt_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Fallback oscillator and glitch-free source switch
  always @(posedge core_clk) begin
    if (rst) begin
      oscCnt_reg <= 8'h00;
      oscClk_reg <= 1'b0;
      useOsc_reg <= 1'b0;
    end else begin
      if (oscCnt_reg >= oscDiv_reg) begin
        oscCnt_reg <= 8'h00;
        oscClk_reg <= ~oscClk_reg;
      end else begin
        oscCnt_reg <= oscCnt_reg + 8'h01;
      end
      // Swap only while both sources are low so the output level never jumps
      if (!rclkS && !oscClk_reg && !parallelClockOut)
        useOsc_reg <= !locked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output state table
  reg  clkEn_next;
  wire clkSrc = useOsc_reg ? oscClk_reg : rclkS;

  always @* begin
    if (!pdnS || state_reg == ST_DOWN)
      clkEn_next = 1'b0;
    else if (locked)
      clkEn_next = oenS && !useOsc_reg;
    else
      clkEn_next = oenS && idleSel && oscSel && cfg_reg[`DOLC_CFG_OSCCK_BIT] && useOsc_reg;
  end

  always @(posedge core_clk) begin
    if (rst) begin
      parallelClockOut    <= 1'b0;
      parallelClockOutEn  <= 1'b0;
      parallelDataLanes   <= 4'h0;
      parallelDataLanesEn <= 4'h0;
      passOut             <= 1'b0;
      passOutEn           <= 1'b0;
    end else begin
      parallelClockOut  <= clkSrc;
      parallelDataLanes <= recoveredData;
      passOut           <= locked && !oenS ? 1'b1 : selfTestResult;
      // Enable moves only while the clock being loaded is low, so no runt pulse leaves the pin;
      // a source stuck high delays the change until it falls
      if (!clkSrc)
        parallelClockOutEn <= clkEn_next;
      if (!pdnS || state_reg == ST_DOWN) begin
        parallelDataLanesEn <= 4'h0;
        passOutEn           <= 1'b0;
      end else if (locked && oenS) begin
        parallelDataLanesEn <= 4'hf;
        passOutEn           <= 1'b1;
      end else if (locked) begin
        parallelDataLanesEn <= 4'h0;
        passOutEn           <= 1'b1;
      end else begin
        parallelDataLanesEn <= 4'h0;
        passOutEn           <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Equalizer and spread spectrum
  always @(posedge core_clk) begin
    if (rst) begin
      rxEqualizerBoost <= 1'b0;
      sscActive        <= 1'b0;
      sscDivider       <= 12'd0;
      sscDeviationCode <= 3'b000;
    end else begin
      rxEqualizerBoost <= regMode ? cfg_reg[`DOLC_CFG_EQ_BIT] : rxEqualizerBoostStrap;
      sscActive        <= (sscSel != 3'b000) && locked;
      sscDivider       <= sscDivFor(lfrSel, sscSel);
      sscDeviationCode <= sscSel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  wire wrFire = awHave_reg && wHave_reg && !s_axi_bvalid;

  always @(posedge core_clk) begin
    if (rst || enterDown) begin
      ctrl_reg   <= 8'h00;
      cfg_reg    <= `DOLC_CFG_RESET;
      oscDiv_reg <= `DOLC_OSCDIV_RESET;
    end else if (wrFire && wStrb_reg[0]) begin
      // Sleep leaves these untouched
      if (awAddr_reg == `DOLC_ADDR_CTRL)
        ctrl_reg <= wData_reg[7:0];
      else if (awAddr_reg == `DOLC_ADDR_CFG)
        cfg_reg <= wData_reg[7:0];
      else if (awAddr_reg == `DOLC_ADDR_OSCDIV)
        oscDiv_reg <= wData_reg[7:0];
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      awAddr_reg    <= 4'h0;
      awHave_reg    <= 1'b0;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      wHave_reg     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_awready <= !awHave_reg && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !wHave_reg && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_reg <= s_axi_awaddr;
        awHave_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
        wHave_reg <= 1'b1;
      end
      if (wrFire) begin
        awHave_reg   <= 1'b0;
        wHave_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr_reg == `DOLC_ADDR_STATUS) ? 2'b00 :
                        (awAddr_reg[1:0] != 2'b00) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        if (s_axi_araddr == `DOLC_ADDR_CTRL)
          s_axi_rdata <= {24'h000000, ctrl_reg};
        else if (s_axi_araddr == `DOLC_ADDR_CFG)
          s_axi_rdata <= {24'h000000, cfg_reg};
        else if (s_axi_araddr == `DOLC_ADDR_STATUS)
          s_axi_rdata <= {24'h000000, useOsc_reg, sleepState, lockOut, 1'b0, state_reg};
        else if (s_axi_araddr == `DOLC_ADDR_OSCDIV)
          s_axi_rdata <= {24'h000000, oscDiv_reg};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* dolc_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module dolc_chk (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        powerDownN,
  input wire logic        outDriveEnable,
  input wire logic        embeddedClkPresent,
  input wire logic        lockOut,
  input wire logic        parallelClockOut,
  input wire logic        parallelClockOutEn,
  input wire logic [3:0]  parallelDataLanesEn,
  input wire logic        passOut,
  input wire logic        passOutEn,
  input wire logic        sleepState,
  input wire logic        sscActive,
  input wire logic [11:0] sscDivider,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Saturating run lengths; 31 leaves room for sync plus clock-phase alignment
  logic [4:0] pdCnt, offCnt, lossCnt, unlCnt;
  always @(posedge core_clk) begin
    if (rst) begin
      pdCnt <= 5'h00;
      offCnt <= 5'h00;
      lossCnt <= 5'h00;
      unlCnt <= 5'h00;
    end else begin
      pdCnt <= powerDownN ? 5'h00 : pdCnt + {4'h0, pdCnt != 5'h1f};
      offCnt <= (lockOut && !outDriveEnable) ? offCnt + {4'h0, offCnt != 5'h1f} : 5'h00;
      lossCnt <= embeddedClkPresent ? 5'h00 : lossCnt + {4'h0, lossCnt != 5'h1f};
      unlCnt <= lockOut ? 5'h00 : unlCnt + {4'h0, unlCnt != 5'h1f};
    end
  end
  property p_pdn; pdCnt == 5'h1f |-> !lockOut && !parallelClockOutEn && parallelDataLanesEn == 4'h0 && !passOutEn;
  endproperty
  a_pdn: assert property (p_pdn) else $error("outputs driven in power down");
  property p_off; offCnt == 5'h1f |-> passOut && passOutEn && !parallelClockOutEn && parallelDataLanesEn == 4'h0;
  endproperty
  a_off: assert property (p_off) else $error("locked undriven state wrong");
  property p_loss; lossCnt == 5'h1f |-> !lockOut; endproperty
  a_loss: assert property (p_loss) else $error("lock kept without embedded clock");
  property p_unl; unlCnt == 5'h1f |-> parallelDataLanesEn == 4'h0 && !passOutEn; endproperty
  a_unl: assert property (p_unl) else $error("lanes driven while unlocked");
  property p_all; parallelDataLanesEn == 4'h0 || parallelDataLanesEn == 4'hf; endproperty
  a_all: assert property (p_all) else $error("lanes enabled partly");
  property p_slp; sleepState |-> !lockOut; endproperty
  a_slp: assert property (p_slp) else $error("lock during sleep");
  property p_ssc; sscActive |-> sscDivider inside {12'd2168, 12'd1300, 12'd625, 12'd385}; endproperty
  a_ssc: assert property (p_ssc) else $error("bad spread divider");
  property p_glt; $changed(parallelClockOutEn) |-> !parallelClockOut; endproperty
  a_glt: assert property (p_glt) else $error("clock enable moved while high");
  property p_bv; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bv: assert property (p_bv) else $error("write response dropped");
  property p_rv; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rv: assert property (p_rv) else $error("read data dropped");
  c_lock: cover property ($rose(lockOut));
  c_sleep: cover property ($rose(sleepState));
  c_ssc: cover property ($rose(sscActive));
endmodule
bind dolc_top dolc_chk CHK (.core_clk, .rst, .powerDownN, .outDriveEnable, .embeddedClkPresent, .lockOut,
  .parallelClockOut, .parallelClockOutEn, .parallelDataLanesEn, .passOut, .passOutEn, .sleepState, .sscActive,
  .sscDivider, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

/* dolc_ser_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dolc_ser_model (
  input  wire logic       streamOn,
  output var  logic       recClk,
  output var  logic       embPresent,
  output var  logic [3:0] data,
  output var  logic       pass
);
  // Link clock stands low between frames; idle data keeps moving so no stale value passes
  initial begin
    recClk = 1'b0;
    embPresent = 1'b0;
    data = 4'h3;
    pass = 1'b1;
    forever begin
      #62.5;
      recClk = streamOn ? ~recClk : 1'b0;
      embPresent = streamOn;
      if (!streamOn) data = ~data;
      else if (recClk) data = data + 4'h5;
    end
  end
endmodule
`default_nettype wire

/* test_deser_output_lock_control.sv */
`timescale 1ns/100ps
`default_nettype none
module test_deser_output_lock_control;
  logic core_clk = 1'b0, rst = 1'b1, powerDownN = 1'b0, outDriveEnable = 1'b0, streamOn = 1'b0;
  logic idleOutputSelectStrap = 1'b0, fallbackOscSelectStrap = 1'b0, rxEqualizerBoostStrap = 1'b0;
  logic lowFreqRangeSelStrap = 1'b0, autoDetectMode = 1'b0;
  logic [2:0] spreadCodeStrap = 3'h0;
  logic recoveredClk, embeddedClkPresent, selfTestResult, lockOut, parallelClockOut, parallelClockOutEn;
  logic passOut, passOutEn, rxEqualizerBoost, sleepState, sscActive, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] recoveredData, parallelDataLanes, parallelDataLanesEn;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [11:0] sscDivider, ex;
  logic [2:0] sscDeviationCode;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  int n_fail = 0, checks = 0, t;
  initial forever #5 core_clk = ~core_clk;
  dolc_top DUT (.core_clk, .rst, .powerDownN, .outDriveEnable, .idleOutputSelectStrap, .fallbackOscSelectStrap,
    .rxEqualizerBoostStrap, .lowFreqRangeSelStrap, .spreadCodeStrap, .autoDetectMode, .recoveredClk,
    .embeddedClkPresent, .recoveredData, .selfTestResult, .lockOut, .parallelClockOut, .parallelClockOutEn,
    .parallelDataLanes, .parallelDataLanesEn, .passOut, .passOutEn, .rxEqualizerBoost, .sleepState, .sscActive,
    .sscDivider, .sscDeviationCode, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dolc_ser_model SER (.streamOn, .recClk(recoveredClk), .embPresent(embeddedClkPresent), .data(recoveredData),
    .pass(selfTestResult));
  task automatic test_done;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic ck(input bit ok, input string m);
    checks++;
    if (!ok) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic axw(input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 100);
    s_axi_bready <= 1'b0;
    ck(n < 100 && s_axi_bresp === 2'b00, "write response");
    @(posedge core_clk);
  endtask
  task automatic axr(input logic [3:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 100);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    ck(n < 100, "read timeout");
    @(posedge core_clk);
  endtask
  task automatic wlock(input logic v);
    t = 0;
    while (lockOut !== v && t < 3000) begin
      @(posedge core_clk);
      t++;
    end
    ck(lockOut === v, "lock level");
  endtask
  task automatic t_lock;
    powerDownN <= 1'b1;
    outDriveEnable <= 1'b1;
    streamOn <= 1'b1;
    cyc(20);
    ck(lockOut === 1'b0, "lock early");
    wlock(1'b1);
    cyc(40);
    @(negedge recoveredClk);
    ck(parallelDataLanesEn === 4'hf && parallelClockOutEn === 1'b1 && passOutEn === 1'b1, "active");
    ck(parallelDataLanes === recoveredData && passOut === selfTestResult, "data path");
    @(posedge core_clk);
    outDriveEnable <= 1'b0;
    cyc(40);
    ck(parallelDataLanesEn === 4'h0 && parallelClockOutEn === 1'b0, "drive off");
    ck(passOut === 1'b1 && passOutEn === 1'b1 && lockOut === 1'b1, "pass high");
    outDriveEnable <= 1'b1;
    cyc(40);
  endtask
  task automatic t_ssc;
    axw(4'h0, 8'h01);
    for (int k = 0; k < 16; k++) begin
      ex = (k[2:0] == 3'h0) ? 12'd0 : (k[2:0] <= 3'h4) ? (k[3] ? 12'd625 : 12'd2168) : (k[3] ? 12'd385 : 12'd1300);
      axw(4'h4, {1'b0, k[2:0], k[3], k[0], 2'b00});
      cyc(4);
      ck(sscDivider === ex && sscActive === (k[2:0] != 3'h0), "spread rate");
      ck(sscDeviationCode === k[2:0] && rxEqualizerBoost === k[0], "spread code");
    end
    axw(4'h0, 8'h00);
    rxEqualizerBoostStrap <= 1'b1;
    lowFreqRangeSelStrap <= 1'b1;
    spreadCodeStrap <= 3'h5;
    cyc(6);
    ck(rxEqualizerBoost === 1'b1 && sscActive === 1'b1 && sscDivider === 12'd385, "strap rule");
    axr(4'h8);
    ck(rd[3:0] === 4'h4 && rd[5] === 1'b1 && rr === 2'b00, "status locked");
    axr(4'h2);
    ck(rr === 2'b10, "misaligned");
  endtask
  task automatic t_sleep;
    axw(4'h0, 8'h01);
    axw(4'h4, 8'h83);
    streamOn <= 1'b0;
    wlock(1'b0);
    cyc(40);
    ck(sleepState === 1'b1 && parallelDataLanesEn === 4'h0 && passOutEn === 1'b0, "sleep");
    ck(parallelClockOutEn === 1'b1, "osc out");
    // Oscillator half period is divider plus one: 5 cycles, so 8 changes in 40
    t = 0;
    rd[0] = parallelClockOut;
    for (int k = 0; k < 40; k++) begin
      @(posedge core_clk);
      if (parallelClockOut !== rd[0]) t++;
      rd[0] = parallelClockOut;
    end
    ck(t == 8, "osc toggles");
    axr(4'h4);
    ck(rd[7:0] === 8'h83, "kept in sleep");
    streamOn <= 1'b1;
    wlock(1'b1);
  endtask
  task automatic t_down;
    autoDetectMode <= 1'b1;
    streamOn <= 1'b0;
    wlock(1'b0);
    cyc(40);
    axr(4'h4);
    ck(rd[7:0] === 8'h00, "auto down reset");
    axr(4'h8);
    ck(rd[3:0] === 4'h1, "auto down");
    streamOn <= 1'b1;
    wlock(1'b1);
    autoDetectMode <= 1'b0;
    axw(4'h0, 8'h01);
    powerDownN <= 1'b0;
    cyc(40);
    ck(lockOut === 1'b0 && parallelClockOutEn === 1'b0 && parallelDataLanesEn === 4'h0, "pdn");
    ck(passOutEn === 1'b0, "pdn pass");
    axr(4'h0);
    ck(rd[7:0] === 8'h00, "pdn reset");
  endtask
  initial begin
    #200000;
    n_fail++;
    test_done;
  end
  initial begin
    cyc(8);
    rst <= 1'b0;
    cyc(2);
    t_lock;
    t_ssc;
    t_sleep;
    t_down;
    test_done;
  end
endmodule
`default_nettype wire
